/* File: rtl/esp_frame_ctrl.sv */
// frame end, slave select, receive buffer and data interrupt gating of the serial port
// Behaviour
// - writing one to the flush bit discards every byte in the receive buffer
// - fill count reads occupancy modulo four; with receive enabled, zero and four told apart by not-empty
// - with the role bit set, after the marked character shifts out, select toggles and marker self-clears
// - when select is an output, the pin follows the select value bit
// - register control of select applies only while the pin is an output
// - flush, marker and select value writable; fill count and reserved read-only
// - data interrupt enable clear masks data sources, errors still interrupt
// - data interrupt enable set lets data sources interrupt along with errors
// - enable bits pick disabled, receive only, transmit only or full duplex
// - one interrupt output pulses when any enabled source first sets
`timescale 1ns/1ps
`include "esp_params.svh"
module esp_frame_ctrl #(
    parameter int BITS_CHAR = `ESP_BITS_CHAR,
    parameter int RX_DEPTH  = `ESP_RX_DEPTH
) (
    // clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // shifter side
    input  wire logic                tx_char_start,
    input  wire logic                rx_push,
    input  wire logic [7:0]          rx_char,
    input  wire logic                tx_holding_empty,
    input  wire esp_pkg::esp_err_type err_flags,
    // link
    input  wire logic                sck_pin,
    output logic                     select_out,
    output logic                     select_oe_n,
    output logic                     tx_force_ones,
    output logic                     rx_holding_not_empty,
    output logic                     irq
);
    localparam int OW = $clog2(RX_DEPTH + 1);
    localparam int PW = $clog2(RX_DEPTH);
    localparam int CW = $clog2(BITS_CHAR);
    localparam logic [OW-1:0] OCC_FULL = OW'(RX_DEPTH);
    localparam logic [CW-1:0] BIT_LAST = CW'(BITS_CHAR - 1);
    localparam logic [7:0]    RST_FRAME = `ESP_RST_FRAME;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    esp_pkg::esp_dphase_type dp;
    logic [7:0]              frame_val;
    logic [7:0]              ctrl;
    logic [7:0]              aux;
    logic [OW-1:0]           occ;
    logic [7:0]              rx_mem [RX_DEPTH];
    logic [PW-1:0]           rd_ptr;
    logic [PW-1:0]           wr_ptr;
    logic                    marker;
    logic                    select_out_value;
    logic                    ft_done;
    logic                    rd_take;
    logic                    wr_frame;
    logic                    wr_flush;

    // true when a word address lies in the register window and has the given index
    function automatic logic esp_hit(input logic [31:0] a, input logic [11:0] idx);
        esp_hit = (a[31:14] == 18'h00000) && (a[13:2] == idx);
    endfunction

    // capture the address phase while the bus is ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp <= '0;
        end else if (hready) begin
            dp.act <= hsel && htrans[1];
            dp.wr  <= hwrite;
            dp.idx <= esp_hit(haddr, haddr[13:2]) ? haddr[13:2] : 12'h000;
        end
    end

    assign rd_take  = dp.act && !dp.wr && !hreadyout;
    assign wr_frame = dp.act && dp.wr && hreadyout && (dp.idx == `ESP_IDX_FRAME);
    assign wr_flush = wr_frame && hwdata[`ESP_FR_FLUSH];

    // read value of a register
    function automatic logic [7:0] esp_read(input logic [11:0] idx);
        unique case (idx)
            `ESP_IDX_DATA:  esp_read = rx_mem[rd_ptr];
            `ESP_IDX_FRAME: esp_read = frame_val;
            `ESP_IDX_CTRL:  esp_read = ctrl;
            `ESP_IDX_AUX:   esp_read = aux;
            `ESP_IDX_STAT:  esp_read = {4'h0, rx_holding_not_empty, 3'(occ)};
            default:        esp_read = 8'h00;
        endcase
    endfunction

    // reads take one wait state so they see writes of the previous transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else if (rd_take) begin
            hreadyout <= 1'b1;
            hrdata    <= {24'h000000, esp_read(dp.idx)};
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hreadyout <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // control is a plain read/write byte; aux keeps only its direction bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `ESP_RST_CTRL;
            aux  <= `ESP_RST_AUX;
        end else if (dp.act && dp.wr && hreadyout) begin
            if (dp.idx == `ESP_IDX_CTRL)
                ctrl <= hwdata[7:0];
            if (dp.idx == `ESP_IDX_AUX)
                aux <= {7'h00, hwdata[`ESP_AX_DIR]};
        end
    end

    // marker: a software set wins over the self-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            marker <= RST_FRAME[`ESP_FR_MARK];
        end else if (wr_frame) begin
            marker <= hwdata[`ESP_FR_MARK];
        end else if (ft_done && ctrl[`ESP_CT_ROLE]) begin
            marker <= 1'b0;
        end
    end

    // select value: a write wins over the end-of-frame toggle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            select_out_value <= RST_FRAME[`ESP_FR_SSV];
        end else if (wr_frame) begin
            select_out_value <= hwdata[`ESP_FR_SSV];
        end else if (ft_done && marker && ctrl[`ESP_CT_ROLE]) begin
            select_out_value <= ~select_out_value;
        end
    end

    // flush reads zero, reserved bits read zero
    assign frame_val = {1'b0, 2'(occ), 3'b000, marker, select_out_value};

    // ----------------------------------------------------------------
    // receive buffer
    // ----------------------------------------------------------------
    logic rx_in;
    logic rx_pop;
    assign rx_in  = rx_push && ctrl[`ESP_CT_EN_LOW] && (occ != OCC_FULL);
    assign rx_pop = rd_take && (dp.idx == `ESP_IDX_DATA) && (occ != '0);

    // storage, written at the tail
    always_ff @(posedge hclk) begin
        if (rx_in)
            rx_mem[wr_ptr] <= rx_char;
    end

    // pointers and occupancy; a byte arriving with the flush is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            occ    <= '0;
            rd_ptr <= '0;
            wr_ptr <= '0;
        end else if (wr_flush) begin
            occ    <= rx_in ? OW'(1) : '0;
            rd_ptr <= wr_ptr;
            wr_ptr <= rx_in ? PW'(wr_ptr + 1'b1) : wr_ptr;
        end else begin
            occ    <= OW'(occ + OW'(rx_in) - OW'(rx_pop));
            rd_ptr <= rx_pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
            wr_ptr <= rx_in ? PW'(wr_ptr + 1'b1) : wr_ptr;
        end
    end

    // ----------------------------------------------------------------
    // link clock sampling and frame tracker
    // ----------------------------------------------------------------
    logic                      sck_s1;
    logic                      sck_s2;
    logic                      sck_s3;
    logic                      sck_trail;
    logic [CW-1:0]             bit_cnt;
    esp_pkg::esp_ft_state_type ft_state;

    // two-stage synchroniser plus an edge history stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
        end else begin
            sck_s1 <= sck_pin;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
        end
    end

    // a bit ends when the clock returns to its idle level
    assign sck_trail = (sck_s2 == ctrl[`ESP_CT_IDLE_LVL]) &&
                       (sck_s3 != ctrl[`ESP_CT_IDLE_LVL]);
    assign ft_done   = (ft_state == esp_pkg::ESP_FT_SHIFT) && sck_trail &&
                       (bit_cnt == BIT_LAST);

    // count the bits of the character being shifted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ft_state <= esp_pkg::ESP_FT_IDLE;
            bit_cnt  <= '0;
        end else begin
            unique case (ft_state)
                esp_pkg::ESP_FT_IDLE: begin
                    bit_cnt <= '0;
                    if (tx_char_start)
                        ft_state <= esp_pkg::ESP_FT_SHIFT;
                end
                esp_pkg::ESP_FT_SHIFT: begin
                    if (ft_done)
                        ft_state <= esp_pkg::ESP_FT_IDLE;
                    else if (sck_trail)
                        bit_cnt <= CW'(bit_cnt + 1'b1);
                end
                default: ft_state <= esp_pkg::ESP_FT_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pins, modes and interrupt
    // ----------------------------------------------------------------
    logic [5:0] src;
    logic [5:0] src_q;
    logic       next_rxne;
    assign next_rxne = (occ != '0) && ctrl[`ESP_CT_EN_LOW];
    // enabled sources: data ones only with the data enable
    assign src = {tx_holding_empty && ctrl[`ESP_CT_EN_HIGH] && ctrl[`ESP_CT_DATA_IRQ_ENABLE],
                  next_rxne && ctrl[`ESP_CT_DATA_IRQ_ENABLE],
                  err_flags};

    // registered pin and flag outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            select_out           <= 1'b1;
            select_oe_n          <= 1'b1;
            tx_force_ones        <= 1'b0;
            rx_holding_not_empty <= 1'b0;
        end else begin
            select_out           <= select_out_value;
            select_oe_n          <= ~aux[`ESP_AX_DIR];
            tx_force_ones        <= !ctrl[`ESP_CT_EN_HIGH] && ctrl[`ESP_CT_EN_LOW];
            rx_holding_not_empty <= wr_flush ? 1'b0 : next_rxne;
        end
    end

    // one pulse when any enabled source first sets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= '0;
            irq   <= 1'b0;
        end else begin
            src_q <= src;
            irq   <= |(src & ~src_q);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_last_bit;
        ft_done && marker && ctrl[`ESP_CT_ROLE] && !wr_frame;
    endsequence
    sequence s_clean_flush;
        wr_flush && !rx_in;
    endsequence

    chk_flush_empties: assert property (s_clean_flush |=> occ == '0)
        else $error("flush left bytes in the buffer");
    chk_fill_wraps: assert property (occ == OCC_FULL |=>
        frame_val[6:5] == 2'b00 || $past(rx_pop) || $past(wr_flush))
        else $error("fill count wrong at full");
    chk_flush_flag: assert property (s_clean_flush |=>
        !rx_holding_not_empty ##1 !rx_holding_not_empty || $past(rx_in))
        else $error("not-empty survived a flush");
    chk_marker_end: assert property (s_last_bit |=> !marker && select_out_value != $past(select_out_value))
        else $error("marker end of frame not handled");
    chk_select_drive: assert property (aux[`ESP_AX_DIR] |=>
        !select_oe_n && select_out == $past(select_out_value))
        else $error("select pin not driven from value bit");
    chk_select_release: assert property (!aux[`ESP_AX_DIR] |=> select_oe_n)
        else $error("select pin driven while input");
    chk_reserved_ro: assert property (wr_frame |=> frame_val[4:2] == 3'b000 &&
        frame_val[7] == 1'b0 && marker == $past(hwdata[`ESP_FR_MARK]))
        else $error("read-only frame bits changed");
    chk_data_masked: assert property (!ctrl[`ESP_CT_DATA_IRQ_ENABLE] && $stable(err_flags) &&
        $stable(ctrl) |=> !irq)
        else $error("data source interrupted while masked");
    chk_data_irq: assert property (ctrl[`ESP_CT_DATA_IRQ_ENABLE] && ctrl[`ESP_CT_EN_HIGH] &&
        $rose(tx_holding_empty) |=> irq)
        else $error("transmit empty gave no interrupt");
    chk_irq_pulse: assert property (irq && $stable(src) |=> !irq)
        else $error("interrupt not a single pulse");
    chk_rx_only: assert property (ctrl[7:0] == 8'h01 |=> tx_force_ones)
        else $error("receive only without all-ones output");
endmodule

/* File: rtl/esp_params.svh */
// offsets, field positions, reset values and counts of the serial port frame control
`ifndef ESP_PARAMS_SVH
`define ESP_PARAMS_SVH
// register indices; byte address is four times the index
`define ESP_IDX_DATA      12'hF60
`define ESP_IDX_FRAME     12'hF61
`define ESP_IDX_CTRL      12'hF62
`define ESP_IDX_AUX       12'hF64
`define ESP_IDX_STAT      12'hF65
// frame_select_rx_buffer_ctrl fields
`define ESP_FR_FLUSH      7
`define ESP_FR_FILL_HI    6
`define ESP_FR_FILL_LO    5
`define ESP_FR_RSV_HI     4
`define ESP_FR_RSV_LO     2
`define ESP_FR_MARK       1
`define ESP_FR_SSV        0
// serial_port_control fields
`define ESP_CT_DATA_IRQ_ENABLE      7
`define ESP_CT_EN_HIGH    6
`define ESP_CT_IDLE_LVL   3
`define ESP_CT_ROLE       1
`define ESP_CT_EN_LOW     0
// aux register fields
`define ESP_AX_DIR        0
// reset values
`define ESP_RST_FRAME     8'h00
`define ESP_RST_CTRL      8'h00
`define ESP_RST_AUX       8'h00
// defaults of counts
`define ESP_BITS_CHAR     8
`define ESP_RX_DEPTH      4
`endif

/* File: rtl/esp_pkg.sv */
// types of the serial port frame control
package esp_pkg;
    // frame tracker states, one-hot
    typedef enum logic [1:0] {
        ESP_FT_IDLE  = 2'b01,
        ESP_FT_SHIFT = 2'b10
    } esp_ft_state_type;
    // error status inputs
    typedef struct packed {
        logic underrun;
        logic collision;
        logic abort;
        logic overrun;
    } esp_err_type;
    // held data phase of the bus
    typedef struct packed {
        logic        act;
        logic        wr;
        logic [11:0] idx;
    } esp_dphase_type;
endpackage

/* File: tb/esp_peer_model.sv */
// serial clock source standing in for the far side of the link
`timescale 1ns/1ps
module esp_peer_model #(
    parameter int HALF_NS = 40
) (
    // link
    input  wire logic idle_lvl,
    output logic      sck
);
    // clock starts low; after each character it stands still at its idle level
    initial begin
        sck = 1'b0;
    end
    // one character: one pulse away from the idle level per bit
    task automatic send_char(input int nbits);
        for (int i = 0; i < nbits; i++) begin
            sck = ~idle_lvl;
            #(HALF_NS);
            sck = idle_lvl;
            #(HALF_NS);
        end
    endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the serial port frame control
`timescale 1ns/1ps
`include "esp_params.svh"
module tb_top;
    localparam logic [31:0] A_DATA  = {18'h0, `ESP_IDX_DATA, 2'b00};
    localparam logic [31:0] A_FRAME = {18'h0, `ESP_IDX_FRAME, 2'b00};
    localparam logic [31:0] A_CTRL  = {18'h0, `ESP_IDX_CTRL, 2'b00};
    localparam logic [31:0] A_AUX   = {18'h0, `ESP_IDX_AUX, 2'b00};
    logic                 hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]          haddr, hwdata, hrdata, rd_q;
    logic [1:0]           htrans;
    logic [7:0]           rx_char;
    logic                 tx_char_start, rx_push, tx_holding_empty, sck_pin, sck_idle;
    logic                 select_out, select_oe_n, tx_force_ones, rx_holding_not_empty, irq;
    esp_pkg::esp_err_type err_flags;
    int                   failures, compares;
    assign hready = hreadyout;
    esp_frame_ctrl #(.BITS_CHAR(8), .RX_DEPTH(4)) esp_frame_ctrl_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .tx_char_start(tx_char_start), .rx_push(rx_push), .rx_char(rx_char),
        .tx_holding_empty(tx_holding_empty), .err_flags(err_flags), .sck_pin(sck_pin),
        .select_out(select_out), .select_oe_n(select_oe_n), .tx_force_ones(tx_force_ones),
        .rx_holding_not_empty(rx_holding_not_empty), .irq(irq));
    esp_peer_model esp_peer_model_i (.idle_lvl(sck_idle), .sck(sck_pin));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic give_verdict();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // sample ready before the edge, data taken at that same edge
    task automatic wait_rdy();
        logic rdy;
        for (int n = 0; n < 40; n++) begin
            @(negedge hclk);
            rdy = hreadyout;
            rd_q = hrdata;
            @(posedge hclk);
            if (rdy === 1'b1) return;
        end
        failures++;
        $display("MISMATCH %0t bus wait ran out", $time);
        give_verdict();
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
        ahb(1'b0, a, 32'h0);
        chk(rd_q, exp, msg);
        chk(hresp, 1'b0, "okay response");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic push(input logic [7:0] v);
        rx_push <= 1'b1;
        rx_char <= v;
        @(posedge hclk);
        rx_push <= 1'b0;
        @(posedge hclk);
    endtask
    // looks for any interrupt pulse in a short window
    task automatic chk_irq(input logic exp, input string msg);
        logic seen;
        seen = 1'b0;
        repeat (6) begin
            @(negedge hclk);
            if (irq === 1'b1) seen = 1'b1;
        end
        @(posedge hclk);
        chk(seen, exp, msg);
    endtask
    task automatic start_char();
        tx_char_start <= 1'b1;
        @(posedge hclk);
        tx_char_start <= 1'b0;
        esp_peer_model_i.send_char(8);
        cyc(6);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk(A_FRAME, 32'h0, "frame reset value");
        rd_chk(A_CTRL, 32'h0, "control reset value");
        wr_reg(32'h0000_0100, 32'hFF);
        rd_chk(32'h0000_0100, 32'h0, "unmapped read");
        chk(select_oe_n, 1'b1, "select released at reset");
    endtask
    task automatic t_fill();
        wr_reg(A_CTRL, 32'h01);
        for (int k = 1; k <= 4; k++) begin
            push(8'(8'hA0 + k));
            rd_chk(A_FRAME, 32'((k % 4) << 5), "fill count");
            chk(rx_holding_not_empty, 1'b1, "not empty while filled");
        end
        rd_chk(A_DATA, 32'hA1, "buffer head");
        rd_chk(A_FRAME, 32'h60, "fill after pop");
        wr_reg(A_FRAME, 32'h80);
        rd_chk(A_FRAME, 32'h0, "fill after flush");
        chk(rx_holding_not_empty, 1'b0, "empty after flush");
        wr_reg(A_FRAME, 32'h60);
        rd_chk(A_FRAME, 32'h0, "read-only bits kept");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr_reg(A_CTRL, 32'(m[1] * 64 + m[0]));
            cyc(3);
            chk(tx_force_ones, m == 1, "all-ones output");
            push(8'h55);
            cyc(2);
            chk(rx_holding_not_empty, m[0], "receive gating");
            wr_reg(A_FRAME, 32'h80);
        end
    endtask
    task automatic t_select();
        wr_reg(A_AUX, 32'h1);
        wr_reg(A_FRAME, 32'h0);
        cyc(3);
        chk(select_oe_n, 1'b0, "select driven");
        chk(select_out, 1'b0, "select low");
        wr_reg(A_FRAME, 32'h1);
        cyc(3);
        chk(select_out, 1'b1, "select high");
        wr_reg(A_AUX, 32'h0);
        cyc(3);
        chk(select_oe_n, 1'b1, "select released");
    endtask
    task automatic t_frame();
        wr_reg(A_CTRL, 32'h43);
        wr_reg(A_AUX, 32'h1);
        wr_reg(A_FRAME, 32'h0);
        start_char();
        rd_chk(A_FRAME, 32'h0, "unmarked char keeps select");
        wr_reg(A_FRAME, 32'h2);
        start_char();
        rd_chk(A_FRAME, 32'h1, "marker clears, value toggles");
        chk(select_out, 1'b1, "pin toggled high");
        wr_reg(A_FRAME, 32'h3);
        start_char();
        rd_chk(A_FRAME, 32'h0, "second toggle");
        chk(select_out, 1'b0, "pin toggled low");
        // same frame end with the serial clock idling high
        wr_reg(A_CTRL, 32'h4B);
        sck_idle <= 1'b1;
        wr_reg(A_FRAME, 32'h2);
        start_char();
        rd_chk(A_FRAME, 32'h1, "toggle with clock idling high");
        chk(select_out, 1'b1, "pin high after idle-high frame");
    endtask
    task automatic t_irq();
        wr_reg(A_CTRL, 32'h41);
        tx_holding_empty <= 1'b1;
        chk_irq(1'b0, "data source masked");
        for (int b = 0; b < 4; b++) begin
            err_flags <= esp_pkg::esp_err_type'(4'b0001 << b);
            chk_irq(1'b1, "error source interrupts");
            err_flags <= 4'h0;
            cyc(1);
        end
        tx_holding_empty <= 1'b0;
        wr_reg(A_CTRL, 32'hC1);
        tx_holding_empty <= 1'b1;
        chk_irq(1'b1, "tx empty interrupts");
        chk_irq(1'b0, "one pulse per rise");
        rx_push <= 1'b1;
        rx_char <= 8'h11;
        @(posedge hclk);
        rx_push <= 1'b0;
        chk_irq(1'b1, "rx not empty interrupts");
        err_flags <= 4'h8;
        chk_irq(1'b1, "error with data enabled");
        err_flags <= 4'h0;
        tx_holding_empty <= 1'b0;
        wr_reg(A_CTRL, 32'h81);
        tx_holding_empty <= 1'b1;
        chk_irq(1'b0, "no tx empty source in receive only");
        wr_reg(A_FRAME, 32'h80);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        failures = 0;
        compares = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        tx_char_start = 1'b0;
        rx_push = 1'b0;
        rx_char = 8'h00;
        tx_holding_empty = 1'b0;
        err_flags = 4'h0;
        sck_idle = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_fill();
        t_modes();
        t_select();
        t_frame();
        t_irq();
        give_verdict();
    end
endmodule
